// file: src/dbg_port.sv
// debug port front end: tap controller, shift chains, mode switch,
// locked-part recovery and commit-protected debug pin settings
// assumes: pins and tck arrive unsynchronised; access port answers
// on clk_sys_i; registers reached over axi4-lite
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_port_map.svh"
module dbg_port
  import dbg_port_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001, // arbitrary identity
  parameter logic [31:0] UNLOCK_KEY = 32'h0000_C0DE // arbitrary key
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic rst_pin_b_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic swd_mode_o,
  input wire logic [31:0] acc_rdata_i,
  input wire logic [`ACK_W-1:0] acc_ack_i,
  output logic acc_req_o,
  output logic [`IR_W-1:0] acc_kind_o,
  output logic [`DR_W-1:0] acc_wdata_o,
  output logic mass_erase_o,
  output logic nv_restore_o,
  output logic [`PIN_N-1:0] pin_alt_function_select_o,
  output logic [`PIN_N-1:0] pin_pullup_select_o,
  output logic [`PIN_N-1:0] pin_digital_enable_o
);
  // ===========================================================
  // helpers
  // next tap state from the tms bit taken on a tck rise
  function automatic tap_state_t tap_next(tap_state_t c, logic m);
    unique case (c)
      TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = m ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
    endcase
  endfunction

  // instruction to chain; unlisted codes fall back to bypass
  function automatic chain_t chain_of(logic [`IR_W-1:0] i);
    if (i == `IR_IDCODE) begin
      chain_of = CH_IDCODE;
    end else if (i == `IR_DPACC || i == `IR_APACC || i == `IR_ABORT) begin
      chain_of = CH_ACCESS;
    end else begin
      chain_of = CH_BYPASS;
    end
  endfunction

  // ===========================================================
  // state and edge terms
  dbg_st_t s_q, s_d; // whole state and its next value
  logic tck_g, tms_g, tdi_g; // pins as the port sees them
  logic rise, fall; // tck edges in the system domain
  logic pin_rst; // synced reset pin held
  logic cmd_done; // 16th command bit just taken
  logic [15:0] hist_n; // history including this bit
  logic wr_go, wr_hit, rd_hit; // bus write fires, address decodes
  logic [2:0] wr_idx, rd_idx; // register index of an address
  chain_t ch; // current data chain

  // decode a byte offset to a register index, 7 when unmapped
  function automatic logic [2:0] reg_idx(logic [7:0] a);
    unique case (a)
      `OFS_AFSEL: reg_idx = 3'h0;
      `OFS_PUR: reg_idx = 3'h1;
      `OFS_DEN: reg_idx = 3'h2;
      `OFS_LOCK: reg_idx = 3'h3;
      `OFS_COMMIT: reg_idx = 3'h4;
      `OFS_STATUS: reg_idx = 3'h5;
      default: reg_idx = 3'h7;
    endcase
  endfunction

  // pins detached from the port read as idle
  always_comb begin
    tck_g = s_q.pin_s[`PIN_TCK] & s_q.afsel[`PIN_TCK];
    tms_g = s_q.pin_s[`PIN_TMS] | ~s_q.afsel[`PIN_TMS];
    tdi_g = s_q.pin_s[`PIN_TDI] | ~s_q.afsel[`PIN_TDI];
    rise = tck_g & ~s_q.tck_prev;
    fall = ~tck_g & s_q.tck_prev;
    pin_rst = ~s_q.pin_s[3];
    hist_n = {tms_g, s_q.hist[15:1]};
    cmd_done = rise && s_q.cmd_cnt == `CMD_LEN - 5'h1;
    ch = chain_of(s_q.ir);
    wr_idx = reg_idx(s_q.aw_a);
    rd_idx = reg_idx(s_axi_araddr);
    wr_hit = wr_idx != 3'h7;
    rd_hit = rd_idx != 3'h7;
    wr_go = s_q.aw_v && s_q.w_v && !s_q.bvalid;
  end

  // ===========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.pin_m = {rst_pin_b_i, tdi_i, tms_i, tck_i};
    s_d.pin_s = s_q.pin_m;
    s_d.tck_prev = tck_g;
    s_d.acc_req = 1'b0;
    s_d.erase = 1'b0;
    s_d.nv_rest = s_q.erase; // restore one cycle after the erase
    // tap walk on each tck rise while jtag is live
    if (rise && !s_q.swd) begin
      s_d.tap = tap_next(s_q.tap, tms_g);
      unique case (s_q.tap)
        TAP_CAP_DR: begin
          unique case (ch)
            CH_IDCODE: s_d.dr_sh = {3'h0, ID_VALUE};
            CH_ACCESS: s_d.dr_sh = {acc_rdata_i, acc_ack_i};
            default: s_d.dr_sh = '0;
          endcase
        end
        TAP_SH_DR: begin
          unique case (ch)
            CH_IDCODE:
              s_d.dr_sh = {3'h0, tdi_g, s_q.dr_sh[`ID_MSB:1]};
            CH_ACCESS: s_d.dr_sh = {tdi_g, s_q.dr_sh[`DR_W-1:1]};
            default: s_d.dr_sh = {{(`DR_W-1){1'b0}}, tdi_g};
          endcase
        end
        TAP_UPD_DR: begin
          if (ch == CH_ACCESS) begin
            s_d.acc_hold = s_q.dr_sh;
            s_d.acc_req = 1'b1;
          end
        end
        TAP_CAP_IR: s_d.ir_sh = 4'h1; // fixed capture pattern
        TAP_SH_IR: s_d.ir_sh = {tdi_g, s_q.ir_sh[`IR_W-1:1]};
        TAP_UPD_IR: s_d.ir = s_q.ir_sh;
        default: begin
          // other states leave the chains alone
        end
      endcase
    end
    // serial-wire side has its own engine; tap parks in reset
    if (s_q.swd || s_d.tap == TAP_TLR) begin
      s_d.tap = TAP_TLR;
      s_d.ir = `IR_IDCODE;
    end
    // tdo changes on the falling edge, driven only while shifting
    if (fall) begin
      s_d.tdo = (s_q.tap == TAP_SH_IR) ? s_q.ir_sh[0] : s_q.dr_sh[0];
      s_d.tdo_oe = !s_q.swd && s_q.afsel[`PIN_TDO] &&
                   (s_q.tap == TAP_SH_DR || s_q.tap == TAP_SH_IR);
    end
    // mode switch detector on the tms stream
    if (rise) begin
      s_d.hist = hist_n;
      s_d.ones = tms_g ? (s_q.ones == `HIGH_RUN ? s_q.ones
                                                : s_q.ones + 6'h1) : 6'h0;
      if (s_q.cmd_cnt != 5'h0) begin
        s_d.cmd_cnt = cmd_done ? 5'h0 : s_q.cmd_cnt + 5'h1;
      end else if (!tms_g && s_q.ones == `HIGH_RUN) begin
        s_d.cmd_cnt = 5'h1; // first command bit after 50 highs
      end
    end
    if (cmd_done && hist_n == `CMD_TO_SWD) begin
      s_d.swd = 1'b1;
    end
    if (cmd_done && hist_n == `CMD_TO_JTAG) begin
      s_d.swd = 1'b0;
      s_d.tap = TAP_TLR;
      s_d.ir = `IR_IDCODE;
    end
    // recovery: count switches while the reset pin is held
    if (!pin_rst) begin
      s_d.sw_cnt = 4'h0;
    end else if (cmd_done &&
                 (hist_n == `CMD_TO_SWD || hist_n == `CMD_TO_JTAG)) begin
      if (s_q.sw_cnt == `RECOVER_CNT - 4'h1) begin
        s_d.sw_cnt = 4'h0;
        s_d.erase = 1'b1;
      end else begin
        s_d.sw_cnt = s_q.sw_cnt + 4'h1;
      end
    end
    // bus: take address and data in either order
    if (s_axi_awvalid && !s_q.aw_v && !s_q.bvalid) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_v && !s_q.bvalid) begin
      s_d.w_v = 1'b1;
      s_d.w_d = s_axi_wdata;
      s_d.w_s = s_axi_wstrb;
    end
    if (wr_go) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (s_q.w_s[0]) begin
        unique case (wr_idx)
          3'h0: s_d.afsel = s_q.unlocked
              ? (s_q.afsel & ~s_q.commit) | (s_q.w_d[4:0] & s_q.commit)
              : s_q.afsel;
          3'h1: s_d.pur = s_q.unlocked
              ? (s_q.pur & ~s_q.commit) | (s_q.w_d[4:0] & s_q.commit)
              : s_q.pur;
          3'h2: s_d.den = s_q.unlocked
              ? (s_q.den & ~s_q.commit) | (s_q.w_d[4:0] & s_q.commit)
              : s_q.den;
          3'h4: s_d.commit = s_q.unlocked ? s_q.w_d[4:0] : s_q.commit;
          default: begin
            // lock is written below, status is read only
          end
        endcase
      end
      if (wr_idx == 3'h3) begin
        s_d.unlocked = s_q.w_s == 4'hF && s_q.w_d == UNLOCK_KEY;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // bus: read answers one cycle after the address
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      unique case (rd_idx)
        3'h0: s_d.rdata = {27'h0, s_q.afsel};
        3'h1: s_d.rdata = {27'h0, s_q.pur};
        3'h2: s_d.rdata = {27'h0, s_q.den};
        3'h3: s_d.rdata = {31'h0, ~s_q.unlocked};
        3'h4: s_d.rdata = {27'h0, s_q.commit};
        3'h5: s_d.rdata = {19'h0, s_q.ir, s_q.tap, s_q.sw_cnt, s_q.swd};
        default: s_d.rdata = 32'h0;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // pin reset restores the debug pin settings and relocks
    if (pin_rst) begin
      s_d.afsel = `AFSEL_RST;
      s_d.pur = `PUR_RST;
      s_d.den = `DEN_RST;
      s_d.commit = `COMMIT_RST;
      s_d.unlocked = 1'b0;
    end
  end

  // ===========================================================
  // registers; power-on reset clears the state except the pin syncs, tck_prev, ir, afsel, pur and den
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.pin_m <= 4'hF;
      s_q.pin_s <= 4'hF;
      s_q.tck_prev <= 1'b1; // matches the synced idle level, no false rise
      s_q.tap <= TAP_TLR;
      s_q.ir <= `IR_IDCODE;
      s_q.afsel <= `AFSEL_RST;
      s_q.pur <= `PUR_RST;
      s_q.den <= `DEN_RST;
      s_q.commit <= `COMMIT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ===========================================================
  // outputs
  assign s_axi_awready = !s_q.aw_v && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_v && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign tdo_o = s_q.tdo;
  assign tdo_oe_o = s_q.tdo_oe;
  assign swd_mode_o = s_q.swd;
  assign acc_req_o = s_q.acc_req;
  assign acc_kind_o = s_q.ir;
  assign acc_wdata_o = s_q.acc_hold;
  assign mass_erase_o = s_q.erase;
  assign nv_restore_o = s_q.nv_rest;
  assign pin_alt_function_select_o = s_q.afsel;
  assign pin_pullup_select_o = s_q.pur;
  assign pin_digital_enable_o = s_q.den;

  // ===========================================================
  // checks
  logic [2:0] hi_run; // tck rises with tms high, saturating
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || (rise && !tms_g)) begin
      hi_run <= 3'h0;
    end else if (rise && hi_run != `TMS_RESET_RUN) begin
      hi_run <= hi_run + 3'h1;
    end
  end
  sequence s_erase_then_restore;
    mass_erase_o ##1 (nv_restore_o && !mass_erase_o);
  endsequence
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  AST_POR_TLR: assert property ($rose(rst_b_i) |-> s_q.tap == TAP_TLR)
    else $error("tap not in reset after power-on reset");
  AST_FIVE_HIGH: assert property (hi_run == `TMS_RESET_RUN |->
    s_q.tap == TAP_TLR) else $error("five high tms did not reset tap");
  AST_CAPTURE: assert property (rise && !s_q.swd && ch == CH_ACCESS &&
    s_q.tap == TAP_CAP_DR |=> s_q.dr_sh == {$past(acc_rdata_i),
    $past(acc_ack_i)}) else $error("capture lost result or ack");
  AST_UPDATE: assert property (rise && !s_q.swd && ch == CH_ACCESS &&
    s_q.tap == TAP_UPD_DR |=> acc_req_o && acc_wdata_o == $past(s_q.dr_sh))
    else $error("update did not move shifted bits");
  AST_PIN_DEFAULT: assert property (pin_rst |=>
    pin_alt_function_select_o == `AFSEL_RST && pin_pullup_select_o ==
    `PUR_RST && pin_digital_enable_o == `DEN_RST)
    else $error("pin reset did not restore pin settings");
  AST_LOCKED: assert property (wr_go && !s_q.unlocked && !pin_rst |=>
    $stable(pin_alt_function_select_o) && $stable(pin_pullup_select_o))
    else $error("locked write changed a protected setting");
  AST_IR_TLR: assert property (s_q.tap == TAP_TLR |->
    s_q.ir == `IR_IDCODE) else $error("reset state without identity op");
  AST_TO_SWD: assert property (cmd_done && hist_n == `CMD_TO_SWD |=>
    swd_mode_o ##1 swd_mode_o) else $error("serial-wire switch missed");
  AST_TO_JTAG: assert property (cmd_done && hist_n == `CMD_TO_JTAG |=>
    !swd_mode_o && s_q.tap == TAP_TLR) else $error("jtag switch missed");
  AST_ERASE: assert property (mass_erase_o |->
    s_erase_then_restore) else $error("erase not followed by restore");
  AST_DETACH: assert property (!s_q.afsel[`PIN_TCK] |=>
    $stable(s_q.tap)) else $error("detached tck still clocks the tap");
endmodule
`default_nettype wire

// file: src/dbg_port_map.svh
// register offsets, reset values, codes and counts of the debug port
// assumes: included by its bare name; the guard makes repeats harmless
`ifndef DBG_PORT_MAP_SVH
`define DBG_PORT_MAP_SVH
// ===========================================================
// register byte offsets
`define OFS_AFSEL 8'h00
`define OFS_PUR 8'h04
`define OFS_DEN 8'h08
`define OFS_LOCK 8'h0C
`define OFS_COMMIT 8'h10
`define OFS_STATUS 8'h14
// ===========================================================
// pin bits: [3:0] tck, tms, tdi, tdo; [4] nmi pin
`define PIN_N 5
`define PIN_TCK 0
`define PIN_TMS 1
`define PIN_TDI 2
`define PIN_TDO 3
`define AFSEL_RST 5'h0F
`define PUR_RST 5'h0F
`define DEN_RST 5'h0F
`define COMMIT_RST 5'h00
// ===========================================================
// instruction codes and chain lengths
`define IR_W 4
`define IR_ABORT 4'h8
`define IR_DPACC 4'hA
`define IR_APACC 4'hB
`define IR_IDCODE 4'hE
`define DR_W 35
`define ACK_W 3
`define ID_MSB 31
// ===========================================================
// mode switch commands, shifted in lsb first
`define CMD_TO_SWD 16'hE79E
`define CMD_TO_JTAG 16'hE73C
`define CMD_LEN 5'h10
`define HIGH_RUN 6'h32
`define RECOVER_CNT 4'hA
`define TMS_RESET_RUN 3'h5
// ===========================================================
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: src/dbg_port_pkg.sv
// types of the debug port front end
// assumes: the map header sits beside it on the include path
package dbg_port_pkg;
  `include "dbg_port_map.svh"
  // ===========================================================
  // tap controller states
  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6,
    TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB, TAP_EX1_IR = 4'hC,
    TAP_PA_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
  } tap_state_t;
  // which chain sits between tdi and tdo
  typedef enum logic [1:0] {
    CH_BYPASS = 2'h0, CH_IDCODE = 2'h1, CH_ACCESS = 2'h2
  } chain_t;
  // ===========================================================
  // whole state of the block
  typedef struct packed {
    logic [3:0] pin_m; // first sync stage {rst, tdi, tms, tck}
    logic [3:0] pin_s; // second sync stage
    logic tck_prev; // last synced tck for edge finding
    tap_state_t tap;
    logic [`IR_W-1:0] ir_sh;
    logic [`IR_W-1:0] ir;
    logic [`DR_W-1:0] dr_sh;
    logic [`DR_W-1:0] acc_hold;
    logic acc_req;
    logic tdo;
    logic tdo_oe;
    logic [5:0] ones; // run of high tms, saturating
    logic [4:0] cmd_cnt; // command bits seen, 0 idle
    logic [15:0] hist; // last 16 tms bits
    logic swd;
    logic [3:0] sw_cnt;
    logic erase;
    logic nv_rest;
    logic [`PIN_N-1:0] afsel;
    logic [`PIN_N-1:0] pur;
    logic [`PIN_N-1:0] den;
    logic [`PIN_N-1:0] commit;
    logic unlocked;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dbg_st_t;
endpackage

// file: tb/dbg_port_bench.sv
// bench of the debug port: clock, reset, bus master, scenarios
// assumes: package and probe model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "dbg_port_map.svh"
module dbg_port_bench;
  import dbg_port_pkg::*;
  localparam logic [31:0] ID_V = 32'h0000_5A31; // arbitrary value
  localparam logic [31:0] KEY_V = 32'h0000_7E11; // arbitrary value
  // ==========
  // signals
  logic clk_sys_i, rst_b_i, rst_pin_b_i, tck, tms, tdi, tdo, tdo_oe, tdo_w;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, swd, acc_req, erase, nv_rest;
  logic [31:0] wdata, rdata, acc_rdata;
  logic [3:0] wstrb, acc_kind;
  logic [1:0] bresp, rresp;
  logic [2:0] acc_ack;
  logic [34:0] acc_wdata;
  logic [4:0] afsel, pur, den;
  int fail_count, total_checks, req_n, erase_n, rest_n;
  assign tdo_w = tdo_oe ? tdo : 1'b1; // pull-up when not driven
  dbg_port #(.ID_VALUE(ID_V), .UNLOCK_KEY(KEY_V)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .rst_pin_b_i(rst_pin_b_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .swd_mode_o(swd), .acc_rdata_i(acc_rdata), .acc_ack_i(acc_ack),
    .acc_req_o(acc_req), .acc_kind_o(acc_kind), .acc_wdata_o(acc_wdata),
    .mass_erase_o(erase), .nv_restore_o(nv_rest),
    .pin_alt_function_select_o(afsel), .pin_pullup_select_o(pur),
    .pin_digital_enable_o(den));
  dbg_probe u_probe (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));
  // ==========
  // clock and pulse counters
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (acc_req === 1'b1) req_n++;
    if (erase === 1'b1) erase_n++;
    if (nv_rest === 1'b1 && erase_n > 0) rest_n++; // restore after erase
  end
  // ==========
  // compare, verdict, bus tasks
  task automatic chk(input string what, input logic [34:0] e,
                     input logic [34:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge clk_sys_i);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      @(posedge clk_sys_i);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", `RESP_OKAY, bresp);
  endtask
  // read one word, compare data and response
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge clk_sys_i);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk_sys_i);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(what, {3'h0, e}, {3'h0, d});
    chk("rresp", er, r);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    rchk("afsel", `OFS_AFSEL, `AFSEL_RST, `RESP_OKAY);
    rchk("pullup", `OFS_PUR, `PUR_RST, `RESP_OKAY);
    rchk("den", `OFS_DEN, `DEN_RST, `RESP_OKAY);
    chk("pin outs", {`AFSEL_RST, `PUR_RST, `DEN_RST}, {afsel, pur, den});
    rchk("status", `OFS_STATUS, {19'h0, `IR_IDCODE, TAP_TLR, 5'h0},
         `RESP_OKAY);
    chk("swd", 1'b0, swd);
    $display("test reset done");
  endtask
  task automatic t_chains();
    logic [34:0] q;
    u_probe.reset_tap();
    u_probe.scan(1'b0, 32, 35'h0, q);
    chk("idcode", {3'h0, ID_V}, q);
    chk("tdo idle", 35'h0, {34'h0, tdo_oe});
    u_probe.scan(1'b1, 4, 35'hF, q);
    chk("ir capture", 35'h1, q);
    rchk("ir", `OFS_STATUS, {19'h0, 4'hF, TAP_RTI, 5'h0}, `RESP_OKAY);
    u_probe.scan(1'b0, 2, 35'h1, q);
    chk("bypass", 35'h2, q);
    u_probe.reset_tap();
    rchk("ir tlr", `OFS_STATUS, {19'h0, `IR_IDCODE, TAP_RTI, 5'h0},
         `RESP_OKAY);
    $display("test chains done");
  endtask
  task automatic t_access();
    logic [34:0] q;
    logic [3:0] k[3] = '{`IR_ABORT, `IR_DPACC, `IR_APACC};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      acc_rdata <= {28'h5A5A_5A5, k[i]};
      acc_ack <= k[i][2:0];
      u_probe.scan(1'b1, 4, {31'h0, k[i]}, q);
      chk("kind", {31'h0, k[i]}, {31'h0, acc_kind});
      u_probe.scan(1'b0, 35, {k[i], 31'h123_4567}, q);
      chk("capture", {28'h5A5A_5A5, k[i], k[i][2:0]}, q);
      chk("acc wdata", {k[i], 31'h123_4567}, acc_wdata);
      chk("acc req", 35'(i + 1), 35'(req_n));
    end
    $display("test access done");
  endtask
  task automatic t_switch();
    u_probe.switch_mode(16'hE79F, 1'b1);
    chk("near miss", 1'b0, swd);
    u_probe.switch_mode(`CMD_TO_SWD, 1'b1);
    chk("swd on", 1'b1, swd);
    u_probe.switch_mode(`CMD_TO_JTAG, 1'b1);
    chk("swd off", 1'b0, swd);
    rchk("tlr", `OFS_STATUS, {19'h0, `IR_IDCODE, TAP_TLR, 5'h0},
         `RESP_OKAY);
    t_chains();
    $display("test switch done");
  endtask
  task automatic t_pins();
    logic [34:0] q;
    wr(`OFS_AFSEL, 32'h0);
    rchk("locked", `OFS_AFSEL, 32'hF, `RESP_OKAY);
    @(posedge clk_sys_i);
    wstrb <= 4'h1;
    wr(`OFS_LOCK, KEY_V);
    rchk("part key", `OFS_LOCK, 32'h1, `RESP_OKAY);
    @(posedge clk_sys_i);
    wstrb <= 4'hF;
    wr(`OFS_LOCK, KEY_V);
    rchk("lock", `OFS_LOCK, 32'h0, `RESP_OKAY);
    wr(`OFS_AFSEL, 32'h0);
    rchk("no commit", `OFS_AFSEL, 32'hF, `RESP_OKAY);
    wr(`OFS_COMMIT, 32'h1F);
    wr(`OFS_AFSEL, 32'h10);
    wr(`OFS_PUR, 32'h0);
    rchk("afsel", `OFS_AFSEL, 32'h10, `RESP_OKAY);
    rchk("pullup", `OFS_PUR, 32'h0, `RESP_OKAY);
    u_probe.scan(1'b0, 32, 35'h0, q);
    rchk("detached", `OFS_STATUS, {19'h0, `IR_IDCODE, TAP_RTI, 5'h0},
         `RESP_OKAY);
    wr(`OFS_LOCK, 32'h0);
    wr(`OFS_DEN, 32'h0);
    rchk("relocked", `OFS_DEN, 32'hF, `RESP_OKAY);
    rchk("unmapped", 8'h40, 32'h0, `RESP_SLVERR);
    @(posedge clk_sys_i);
    rst_pin_b_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_pin_b_i <= 1'b1;
    rchk("pin reset", `OFS_PUR, `PUR_RST, `RESP_OKAY);
    chk("pin outs", {`AFSEL_RST, `PUR_RST}, {afsel, pur});
    $display("test pins done");
  endtask
  task automatic t_recover();
    @(posedge clk_sys_i);
    rst_pin_b_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (i == 9) chk("early erase", 35'h0, 35'(erase_n));
      u_probe.switch_mode(i[0] ? `CMD_TO_JTAG : `CMD_TO_SWD, 1'b0);
    end
    repeat (4) @(posedge clk_sys_i);
    chk("erase", 35'h1, 35'(erase_n));
    chk("restore", 35'h1, 35'(rest_n));
    rst_pin_b_i <= 1'b1;
    chk("jtag after", 1'b0, swd);
    $display("test recover done");
  endtask
  // ==========
  // watchdog: tests need about 80 us of simulated time
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  // main sequence
  initial begin
    rst_b_i = 1'b0;
    rst_pin_b_i = 1'b1;
    {awaddr, araddr, wdata, acc_rdata, acc_ack} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_chains();
    t_access();
    t_switch();
    t_pins();
    t_recover();
    complete_run();
  end
endmodule
`default_nettype wire

// file: tb/dbg_probe.sv
// probe model: drives debug clock, mode select and data in, reads tdo
// assumes: tasks are called one at a time; debug clock period 64 ns
`timescale 1ns/1ps
`default_nettype none
module dbg_probe (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // ==========
  // idle levels: clock parked low, lines at their pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // one clock: levels set while low, tdo taken at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #32 tck_o = 1'b1;
    q = tdo_i;
    #32 tck_o = 1'b0;
  endtask
  // n clocks with a fixed mode select level
  task automatic run(input int n, input logic m);
    logic q;
    repeat (n) tick(m, 1'b1, q);
    tms_o = 1'b1;
  endtask
  // five high clocks, then park in run-test-idle
  task automatic reset_tap();
    run(5, 1'b1);
    run(1, 1'b0);
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir_path, input int n,
                      input logic [34:0] din, output logic [34:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b1, q);
    if (ir_path) tick(1'b1, 1'b1, q);
    run(2, 1'b0);
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    tick(1'b1, 1'b1, q);
    run(1, 1'b0);
  endtask
  // high run, 16-bit command lsb first, trailing run if asked
  task automatic switch_mode(input logic [15:0] cmd, input logic trail);
    logic q;
    run(50, 1'b1);
    for (int i = 0; i < 16; i++) tick(cmd[i], 1'b1, q);
    if (trail) run(50, 1'b1);
    tms_o = 1'b1;
  endtask
endmodule
`default_nettype wire
